// >>> pkg/hpb_pkg.sv
// constants and types shared by the pass-through bridge
package hpb_pkg;
  localparam int HPB_CLK_HZ = 50_000_000;
  localparam int HPB_TICK_S = 1;
  localparam int HPB_TICK_CYCLES = HPB_CLK_HZ * HPB_TICK_S;
  localparam int HPB_NUM_CHAN = 4;
  localparam int HPB_QUEUE_DEPTH = 2;
  localparam int HPB_FIFO_DEPTH = 8;
  localparam int HPB_ADDR_BYTES = 5;
  localparam logic [7:0] HPB_CMD_PASS = 8'h01;
  localparam logic [7:0] HPB_CMD_QUERY = 8'h0C;
  localparam logic [7:0] HPB_DELIM = 8'h82;
  localparam logic [7:0] HPB_ST_SUCCESS = 8'h00;
  localparam logic [7:0] HPB_ST_BUSY = 8'h20;
  localparam logic [7:0] HPB_REQUEST_ACCEPTED_CODE = 8'h21;
  localparam logic [7:0] HPB_RESULT_PENDING_CODE = 8'h22;
  localparam logic [7:0] HPB_REQUEST_REJECTED_CODE = 8'h23;
  localparam logic [7:0] HPB_REPLY_COUNT = 8'h01;
  localparam logic [7:0] HPB_HANDLE_NONE = 8'h00;
  localparam logic [7:0] HPB_HANDLE_MIN = 8'h01;
  localparam logic [7:0] HPB_HANDLE_MAX = 8'hFF;
  localparam logic [7:0] HPB_TIMEOUT_MIN = 8'h01;
  // byte positions within a request, counted from the channel byte
  localparam logic [8:0] HPB_POS_CMD = 9'h001;
  localparam logic [8:0] HPB_POS_DELIM = 9'h002;
  localparam logic [8:0] HPB_POS_ADDR = 9'h003;
  localparam logic [8:0] HPB_POS_ADDR_END = 9'h007;
  localparam logic [8:0] HPB_POS_BC = 9'h009;
  localparam logic [8:0] HPB_POS_DATA = 9'h00A;
  localparam logic [8:0] HPB_HDR_BYTES = 9'h002;
  localparam logic [8:0] HPB_FRAME_FIXED = 9'h009;
  localparam logic [8:0] HPB_QUERY_LEN = 9'h003;
  localparam logic [8:0] HPB_POS_MAX = 9'h1FF;
  typedef enum logic [1:0] {SLOT_FREE, SLOT_QUEUED, SLOT_BUSY, SLOT_HOLD} hpb_slot_t;
  typedef struct packed {
    hpb_slot_t state;
    logic [1:0] chan;
    logic [7:0] handle;
    logic [7:0] timer;
  } hpb_entry_t;
endpackage

// >>> rtl/hpb_bridge.sv
// pass-through request queue, checker and reply engine, with its input FIFO
`timescale 1ns/1ns
`default_nettype none

module hpb_fifo
  import hpb_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = HPB_FIFO_DEPTH
)
(
  input wire logic clock, // system clock
  input wire logic nrst, // synchronous reset, low
  input wire logic inValid, // write side offers a word
  input wire logic [WIDTH-1:0] inData, // word written
  output logic inReady, // room for a word
  output logic outValid, // a word is waiting
  output logic [WIDTH-1:0] outData, // oldest word
  input wire logic outReady // read side takes the word
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic rdy;
  } hpb_fifo_t;
  hpb_fifo_t s;
  hpb_fifo_t n;
  logic push;
  logic pop;

  assign push = inValid && s.rdy;
  assign pop = outReady && (s.cnt != '0);
  assign inReady = s.rdy;
  assign outValid = (s.cnt != '0);
  assign outData = s.mem[s.rp];

  always_comb
  begin
    n = s;
    if (push)
    begin
      n.mem[s.wp] = inData;
      n.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop)
      n.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    n.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
    // ready is registered so the port comes straight from a flop
    n.rdy = (n.cnt != (PW+1)'(DEPTH));
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      s <= '{default: '0, rdy: 1'b1};
    else
      s <= n;
  end
endmodule // hpb_fifo

module hpb_bridge
  import hpb_pkg::*;
#(
  parameter int TICK_CYCLES = HPB_TICK_CYCLES
)
(
  input wire logic clock, // system clock, 50 MHz
  input wire logic nrst, // synchronous reset, low
  input wire logic inValid, // host request byte offered
  input wire logic [7:0] inData, // host request byte
  input wire logic inLast, // last byte of the request
  output logic inReady, // FIFO can take a byte
  output logic outValid, // reply byte offered
  output logic [7:0] outData, // reply byte
  output logic outLast, // last byte of the reply
  input wire logic outReady, // host takes the reply byte
  input wire logic [3:0] chanEnable, // channel enabled
  input wire logic [3:0] chanLinked, // field device address known
  input wire logic [3:0] infoBusy, // device information gathering
  input wire logic [159:0] chanAddr, // long addresses, channel 0 lowest
  input wire logic scanDone, // one full scan completed
  input wire logic [7:0] timeoutSec, // handle timeout in seconds
  output logic dispValid, // pulse: entry handed to the field link
  output logic [1:0] dispChan, // channel of the dispatched entry
  output logic [7:0] dispHandle, // handle of the dispatched entry
  input wire logic fieldDone, // pulse: field answer stored
  input wire logic [7:0] fieldHandle // handle of that answer
);
  localparam int TW = $clog2(TICK_CYCLES);
  typedef struct packed {
    logic [TW-1:0] tickCnt;
    hpb_entry_t [HPB_QUEUE_DEPTH-1:0] ent;
    logic [7:0] hndCtr;
    logic scanSeen;
    logic [8:0] idx;
    logic [7:0] chan;
    logic [7:0] cmd;
    logic [7:0] bc;
    logic [7:0] xorAcc;
    logic frameOk;
    logic [3:0][7:0] rBuf;
    logic [1:0] rIdx;
    logic outValid_r;
    logic [7:0] outData_r;
    logic outLast_r;
    logic dispValid_r;
    logic [1:0] dispChan_r;
    logic [7:0] dispHandle_r;
  } hpb_state_t;
  hpb_state_t s;
  hpb_state_t n;

  logic fValid;
  logic [8:0] fData;
  logic pop;
  logic [7:0] b;
  logic tick;
  logic chanOk;
  logic evalPass;
  logic evalQry;
  logic passOk;
  logic isFull;
  logic chanPending;
  logic acceptNow;
  logic freeIdx;
  logic [7:0] tmo;
  logic [7:0] newHandle;

  function automatic logic [7:0] nextHandle(input logic [7:0] h);
    nextHandle = (h == HPB_HANDLE_MAX) ? HPB_HANDLE_MIN : h + 8'h01;
  endfunction

  function automatic logic [7:0] addrByte(input logic [159:0] a, input logic [1:0] ch, input logic [8:0] i);
    logic [2:0] k;
    k = 3'(i - HPB_POS_ADDR);
    // the long address arrives most significant byte first
    addrByte = a[({6'h00, ch} * 8'h28) + ((8'h04 - {5'h00, k}) * 8'h08) +: 8];
  endfunction

  // bytes wait here while a reply is going out; back-pressure reaches the host
  hpb_fifo #(.WIDTH(9), .DEPTH(HPB_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .inValid(inValid),
    .inData({inLast, inData}),
    .inReady(inReady),
    .outValid(fValid),
    .outData(fData),
    .outReady(!s.outValid_r)
  );

  assign pop = fValid && !s.outValid_r;
  assign b = fData[7:0];
  assign tick = (s.tickCnt == TW'(TICK_CYCLES - 1));
  assign tmo = (timeoutSec < HPB_TIMEOUT_MIN) ? HPB_TIMEOUT_MIN : timeoutSec;
  assign chanOk = (s.chan < 8'(HPB_NUM_CHAN)) && chanEnable[s.chan[1:0]];
  assign evalPass = pop && fData[8] && (s.cmd == HPB_CMD_PASS) && (s.idx > HPB_POS_CMD);
  assign evalQry = pop && fData[8] && (s.cmd == HPB_CMD_QUERY) && (s.idx > HPB_POS_CMD);
  // request length minus two must equal the frame the byte count describes
  assign passOk = chanOk && chanLinked[s.chan[1:0]] && !infoBusy[s.chan[1:0]]
    && (s.idx >= HPB_POS_DATA) && (s.idx - HPB_HDR_BYTES + 9'h001 == HPB_FRAME_FIXED + {1'b0, s.bc})
    && s.frameOk && (b == s.xorAcc);
  assign isFull = (s.ent[0].state != SLOT_FREE) && (s.ent[1].state != SLOT_FREE);
  assign chanPending = ((s.ent[0].state != SLOT_FREE) && (s.ent[0].chan == s.chan[1:0]))
    || ((s.ent[1].state != SLOT_FREE) && (s.ent[1].chan == s.chan[1:0]));
  assign acceptNow = evalPass && passOk && !isFull && !chanPending;
  assign freeIdx = (s.ent[0].state != SLOT_FREE);
  // skip a value still held by the other entry
  assign newHandle = ((s.ent[!freeIdx].state != SLOT_FREE) && (nextHandle(s.hndCtr) == s.ent[!freeIdx].handle))
    ? nextHandle(nextHandle(s.hndCtr)) : nextHandle(s.hndCtr);

  assign outValid = s.outValid_r;
  assign outData = s.outData_r;
  assign outLast = s.outLast_r;
  assign dispValid = s.dispValid_r;
  assign dispChan = s.dispChan_r;
  assign dispHandle = s.dispHandle_r;

  always_comb
  begin
    logic busyAny;
    logic [7:0] st;
    logic [7:0] hd;
    busyAny = (s.ent[0].state == SLOT_BUSY) || (s.ent[1].state == SLOT_BUSY);
    st = HPB_REQUEST_REJECTED_CODE;
    hd = HPB_HANDLE_NONE;
    n = s;
    n.dispValid_r = 1'b0;
    n.tickCnt = tick ? '0 : s.tickCnt + 1'b1;
    for (int e = 0; e < HPB_QUEUE_DEPTH; e++)
    begin
      if (fieldDone && (s.ent[e].state == SLOT_BUSY) && (s.ent[e].handle == fieldHandle))
      begin
        n.ent[e].state = SLOT_HOLD;
        n.ent[e].timer = tmo;
      end
      else if ((s.ent[e].state == SLOT_HOLD) && tick)
      begin
        if (s.ent[e].timer <= HPB_TIMEOUT_MIN)
          n.ent[e].state = SLOT_FREE;
        else
          n.ent[e].timer = s.ent[e].timer - 8'h01;
      end
    end
    // one field transaction at a time, and only after a fresh scan
    if (!busyAny && s.scanSeen && ((s.ent[0].state == SLOT_QUEUED) || (s.ent[1].state == SLOT_QUEUED)))
    begin
      for (int e = HPB_QUEUE_DEPTH - 1; e >= 0; e--)
      begin
        if (s.ent[e].state == SLOT_QUEUED)
        begin
          n.dispChan_r = s.ent[e].chan;
          n.dispHandle_r = s.ent[e].handle;
        end
      end
      if (s.ent[0].state == SLOT_QUEUED)
        n.ent[0].state = SLOT_BUSY;
      else
        n.ent[1].state = SLOT_BUSY;
      n.dispValid_r = 1'b1;
      n.scanSeen = 1'b0;
    end
    if (scanDone)
      n.scanSeen = 1'b1;
    if (pop)
    begin
      n.idx = (s.idx == HPB_POS_MAX) ? s.idx : s.idx + 9'h001;
      if (s.idx == 9'h000)
        n.chan = b;
      if (s.idx == HPB_POS_CMD)
        n.cmd = b;
      if (s.idx >= HPB_POS_DELIM)
        n.xorAcc = s.xorAcc ^ b;
      if ((s.idx == HPB_POS_DELIM) && (b != HPB_DELIM))
        n.frameOk = 1'b0;
      if ((s.idx >= HPB_POS_ADDR) && (s.idx <= HPB_POS_ADDR_END))
      begin
        if ((s.chan >= 8'(HPB_NUM_CHAN)) || (b != addrByte(chanAddr, s.chan[1:0], s.idx)))
          n.frameOk = 1'b0;
      end
      if (s.idx == HPB_POS_BC)
        n.bc = b;
      if (fData[8])
      begin
        if (evalPass)
        begin
          if (isFull)
            st = HPB_ST_BUSY;
          else if (acceptNow)
          begin
            st = HPB_REQUEST_ACCEPTED_CODE;
            hd = newHandle;
            n.hndCtr = newHandle;
            n.ent[freeIdx].state = SLOT_QUEUED;
            n.ent[freeIdx].chan = s.chan[1:0];
            n.ent[freeIdx].handle = newHandle;
            n.ent[freeIdx].timer = '0;
          end
        end
        else if (evalQry && chanOk && (s.idx + 9'h001 == HPB_QUERY_LEN))
        begin
          hd = b;
          for (int e = 0; e < HPB_QUEUE_DEPTH; e++)
          begin
            if ((s.ent[e].state != SLOT_FREE) && (s.ent[e].chan == s.chan[1:0]) && (s.ent[e].handle == b))
            begin
              if (s.ent[e].state == SLOT_HOLD)
              begin
                st = HPB_ST_SUCCESS;
                n.ent[e].state = SLOT_FREE;
              end
              else
                st = HPB_RESULT_PENDING_CODE;
            end
          end
        end
        // status reflects the state sampled as the last byte arrives
        n.rBuf = {hd, HPB_REPLY_COUNT, st, s.chan};
        n.outValid_r = 1'b1;
        n.outData_r = s.chan;
        n.outLast_r = 1'b0;
        n.rIdx = 2'h1;
        n.idx = '0;
        n.cmd = '0;
        n.xorAcc = '0;
        n.frameOk = 1'b1;
      end
    end
    else if (s.outValid_r && outReady)
    begin
      if (s.outLast_r)
        n.outValid_r = 1'b0;
      else
      begin
        n.outData_r = s.rBuf[s.rIdx];
        n.outLast_r = (s.rIdx == 2'h3);
        n.rIdx = s.rIdx + 2'h1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      s <= '{default: '0, frameOk: 1'b1};
    else
      s <= n;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_reply_start;
    s.outValid_r && (s.outData_r == s.rBuf[0]) && (s.rIdx == 2'h1);
  endsequence
  sequence s_second_beat;
    s.outValid_r && outReady && (s.rIdx == 2'h1) && !s.outLast_r;
  endsequence

  a_queue_full_busy: assert property (evalPass && isFull |=> s_reply_start
    ##0 (s.rBuf[1] == HPB_ST_BUSY) && (s.rBuf[3] == HPB_HANDLE_NONE))
    else $error("full queue did not answer busy");
  a_reject_invalid: assert property (evalPass && !passOk |=> (s.rBuf[1] == HPB_REQUEST_REJECTED_CODE)
    || (s.rBuf[1] == HPB_ST_BUSY))
    else $error("invalid request not rejected");
  a_accept_handle: assert property (acceptNow |=> (s.rBuf[1] == HPB_REQUEST_ACCEPTED_CODE)
    && (s.rBuf[2] == HPB_REPLY_COUNT) && (s.rBuf[3] != HPB_HANDLE_NONE))
    else $error("accepted reply lacks count or handle");
  a_dispatch_scan: assert property (s.dispValid_r |-> $past(s.scanSeen)
    && !$past(s.ent[0].state == SLOT_BUSY) && !$past(s.ent[1].state == SLOT_BUSY))
    else $error("dispatch without fresh scan");
  a_hold_timer: assert property (fieldDone && (s.ent[0].state == SLOT_BUSY) && (s.ent[0].handle == fieldHandle)
    |=> (s.ent[0].state == SLOT_HOLD) && (s.ent[0].timer == $past(tmo)))
    else $error("answer did not start the hold timer");
  a_expire_free: assert property ((s.ent[1].state == SLOT_HOLD) && tick && (s.ent[1].timer == HPB_TIMEOUT_MIN)
    |=> (s.ent[1].state == SLOT_FREE))
    else $error("expired entry not freed");
  a_timer_range: assert property ((s.ent[0].state == SLOT_HOLD) |-> (s.ent[0].timer >= HPB_TIMEOUT_MIN)
    && (s.ent[0].timer <= $past(tmo, 1) || $past(s.ent[0].state == SLOT_HOLD)))
    else $error("hold timer out of range");
  a_tick_wrap: assert property (tick |=> (s.tickCnt == '0) ##1 (s.tickCnt == TW'(1)))
    else $error("second prescaler misbehaves");
  a_status_second: assert property (s_second_beat |=> (s.outData_r == $past(s.rBuf[1])))
    else $error("status not second reply byte");
  a_query_free: assert property (evalQry && (s.rBuf[1] != HPB_ST_SUCCESS) ##1 (s.rBuf[1] == HPB_ST_SUCCESS)
    |-> (s.ent[0].state != SLOT_HOLD) || (s.ent[0].handle != s.rBuf[3]))
    else $error("queried handle still held");
  a_query_pending: assert property (evalQry && chanOk && (s.ent[0].state == SLOT_QUEUED)
    && (s.ent[0].handle == b) && (s.ent[0].chan == s.chan[1:0]) && (s.idx == 9'h002)
    |=> (s.rBuf[1] == HPB_RESULT_PENDING_CODE))
    else $error("pending query not answered 34");
  a_handle_unique: assert property ((s.ent[0].state != SLOT_FREE) && (s.ent[1].state != SLOT_FREE)
    |-> (s.ent[0].handle != s.ent[1].handle) && (s.ent[0].handle != HPB_HANDLE_NONE))
    else $error("duplicate or zero active handle");
endmodule // hpb_bridge

`default_nettype wire

// >>> tb/hpb_host_model.sv
// host controller model: sends request bytes and collects four-byte replies
`timescale 1ns/1ns
`default_nettype none

module hpb_host_model
  import hpb_pkg::*;
(
  input wire logic clock, // system clock
  output logic inValid, // request byte offered
  output logic [7:0] inData, // request byte
  output logic inLast, // final request byte
  input wire logic inReady, // bridge takes bytes
  input wire logic outValid, // reply byte offered
  input wire logic [7:0] outData, // reply byte
  input wire logic outLast, // final reply byte
  output logic outReady // host takes reply byte
);
  logic [7:0] rep [4];
  logic [3:0] lastSeen;
  int stall;

  initial
  begin
    inValid = 1'b0;
    inData = 8'h00;
    inLast = 1'b0;
    outReady = 1'b0;
    stall = 0;
  end

  // whole message first, then the reply is read back before anything else
  task automatic send(input logic [7:0] m[$]);
    for (int i = 0; i < m.size(); i++)
    begin
      inValid = 1'b1;
      inData = m[i];
      inLast = (i == m.size() - 1);
      do @(negedge clock); while (inReady !== 1'b1);
      @(posedge clock);
      #1;
    end
    inValid = 1'b0;
    inLast = 1'b0;
    // released bus must not look like a repeat of the last byte
    inData = ~inData;
    for (int j = 0; j < 4; j++)
    begin
      // raise ready just after an edge, never on it, or the bridge may see it a cycle early
      if (stall > 0)
      begin
        repeat (stall) @(posedge clock);
        #1;
      end
      outReady = 1'b1;
      do @(negedge clock); while (outValid !== 1'b1);
      rep[j] = outData;
      lastSeen[j] = outLast;
      @(posedge clock);
      #1;
      if (stall > 0)
        outReady = 1'b0;
    end
    outReady = 1'b0;
  endtask
endmodule // hpb_host_model

`default_nettype wire

// >>> tb/tb_hpb_bridge.sv
// self-checking bench for the pass-through bridge
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module tb_hpb_bridge
  import hpb_pkg::*;
;
  logic clock, nrst, inValid, inLast, inReady, outValid, outLast, outReady;
  logic [7:0] inData, outData, timeoutSec, dispHandle, fieldHandle;
  logic [3:0] chanEnable, chanLinked, infoBusy;
  logic [159:0] chanAddr;
  logic scanDone, dispValid, fieldDone;
  logic [1:0] dispChan;
  int miscompares, cmpCount, cycles, dispCnt;

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  hpb_bridge #(.TICK_CYCLES(8)) dut_u (.clock(clock), .nrst(nrst), .inValid(inValid), .inData(inData),
    .inLast(inLast), .inReady(inReady), .outValid(outValid), .outData(outData), .outLast(outLast),
    .outReady(outReady), .chanEnable(chanEnable), .chanLinked(chanLinked), .infoBusy(infoBusy),
    .chanAddr(chanAddr), .scanDone(scanDone), .timeoutSec(timeoutSec), .dispValid(dispValid),
    .dispChan(dispChan), .dispHandle(dispHandle), .fieldDone(fieldDone), .fieldHandle(fieldHandle));

  hpb_host_model host_u (.clock(clock), .inValid(inValid), .inData(inData), .inLast(inLast),
    .inReady(inReady), .outValid(outValid), .outData(outData), .outLast(outLast), .outReady(outReady));

  always @(negedge clock)
  begin
    if (dispValid === 1'b1)
      dispCnt++;
  end

  // generous ceiling: the sequence needs well under two thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // kind: 0 good, 1 bad delimiter, 2 bad address, 3 bad checksum, 4 extra byte
  task automatic build(input int ch, input int kind, output logic [7:0] m[$]);
    logic [7:0] cks;
    int c;
    c = ch % 4;
    m = {8'(ch), HPB_CMD_PASS, (kind == 1) ? 8'h81 : HPB_DELIM};
    for (int i = 0; i < 5; i++)
      m.push_back(chanAddr[40*c+32-8*i +: 8] ^ ((kind == 2 && i == 4) ? 8'h01 : 8'h00));
    m.push_back(8'h03);
    m.push_back(8'h02);
    // two-byte value sent most significant byte first
    m.push_back(8'h12);
    m.push_back(8'h34);
    cks = 8'h00;
    for (int i = 2; i < m.size(); i++)
      cks ^= m[i];
    m.push_back((kind == 3) ? ~cks : cks);
    if (kind == 4)
      m.push_back(8'h00);
  endtask

  task automatic req(input int ch, input int kind, input logic [7:0] expSt, input logic [7:0] expH);
    logic [7:0] m[$];
    build(ch, kind, m);
    host_u.send(m);
    `CHK("reply chan", 8'(ch), host_u.rep[0])
    `CHK("reply status", expSt, host_u.rep[1])
    `CHK("reply count", HPB_REPLY_COUNT, host_u.rep[2])
    `CHK("reply handle", expH, host_u.rep[3])
    `CHK("reply last", 4'b1000, host_u.lastSeen)
  endtask

  task automatic qry(input int ch, input logic [7:0] h, input logic [7:0] expSt);
    host_u.send({8'(ch), HPB_CMD_QUERY, h});
    `CHK("query status", expSt, host_u.rep[1])
    `CHK("query handle", h, host_u.rep[3])
  endtask

  task automatic pulse(input logic isField, input logic [7:0] h);
    @(posedge clock);
    #1;
    scanDone = ~isField;
    fieldDone = isField;
    fieldHandle = h;
    @(posedge clock);
    #1;
    scanDone = 1'b0;
    fieldDone = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic test_accept();
    `CHK("ready idle", 1'b1, inReady)
    req(0, 0, HPB_REQUEST_ACCEPTED_CODE, 8'h01);
    repeat (20) @(posedge clock);
    #1;
    `CHK("no dispatch before scan", 0, dispCnt)
    pulse(1'b0, 8'h00);
    `CHK("dispatch after scan", 1, dispCnt)
    `CHK("dispatch chan", 2'h0, dispChan)
    `CHK("dispatch handle", 8'h01, dispHandle)
    $display("test accept done");
  endtask

  task automatic test_query();
    qry(0, 8'h01, HPB_RESULT_PENDING_CODE);
    pulse(1'b1, 8'h01);
    qry(0, 8'h01, HPB_ST_SUCCESS);
    qry(0, 8'h01, HPB_REQUEST_REJECTED_CODE);
    $display("test query done");
  endtask

  task automatic test_full_timeout();
    req(0, 0, HPB_REQUEST_ACCEPTED_CODE, 8'h02);
    req(1, 0, HPB_REQUEST_ACCEPTED_CODE, 8'h03);
    qry(0, 8'h02, HPB_RESULT_PENDING_CODE);
    req(2, 0, HPB_ST_BUSY, HPB_HANDLE_NONE);
    pulse(1'b0, 8'h00);
    `CHK("first of two", 8'h02, dispHandle)
    pulse(1'b1, 8'h02);
    `CHK("one in service", 2, dispCnt)
    pulse(1'b0, 8'h00);
    `CHK("second dispatch", 8'h03, dispHandle)
    pulse(1'b1, 8'h03);
    qry(1, 8'h03, HPB_ST_SUCCESS);
    repeat (80) @(posedge clock);
    #1;
    qry(0, 8'h02, HPB_REQUEST_REJECTED_CODE);
    req(2, 0, HPB_REQUEST_ACCEPTED_CODE, 8'h04);
    // zero seconds is taken as one: the hold ends within one tick, long before three
    timeoutSec = 8'h00;
    pulse(1'b0, 8'h00);
    `CHK("third dispatch", 8'h04, dispHandle)
    pulse(1'b1, 8'h04);
    repeat (4) @(posedge clock);
    #1;
    qry(2, 8'h04, HPB_REQUEST_REJECTED_CODE);
    timeoutSec = 8'h03;
    $display("test full and timeout done");
  endtask

  task automatic test_reject();
    host_u.stall = 3;
    for (int k = 1; k <= 4; k++)
      req(3, k, HPB_REQUEST_REJECTED_CODE, HPB_HANDLE_NONE);
    req(4, 0, HPB_REQUEST_REJECTED_CODE, HPB_HANDLE_NONE);
    chanEnable = 4'h7;
    req(3, 0, HPB_REQUEST_REJECTED_CODE, HPB_HANDLE_NONE);
    chanEnable = 4'hF;
    chanLinked = 4'h7;
    req(3, 0, HPB_REQUEST_REJECTED_CODE, HPB_HANDLE_NONE);
    chanLinked = 4'hF;
    infoBusy = 4'h8;
    req(3, 0, HPB_REQUEST_REJECTED_CODE, HPB_HANDLE_NONE);
    infoBusy = 4'h0;
    host_u.stall = 0;
    req(3, 0, HPB_REQUEST_ACCEPTED_CODE, 8'h05);
    $display("test reject done");
  endtask

  initial
  begin
    nrst = 1'b0;
    chanEnable = 4'hF;
    chanLinked = 4'hF;
    infoBusy = 4'h0;
    chanAddr = {40'h3132333435, 40'h2122232425, 40'h1112131415, 40'h0102030405};
    scanDone = 1'b0;
    fieldDone = 1'b0;
    fieldHandle = 8'h00;
    timeoutSec = 8'h03;
    miscompares = 0;
    cmpCount = 0;
    cycles = 0;
    dispCnt = 0;
    repeat (16) @(posedge clock);
    #1;
    nrst = 1'b1;
    test_accept();
    test_query();
    test_full_timeout();
    test_reject();
    close_out();
  end
endmodule // tb_hpb_bridge

`default_nettype wire
